/* common/miex_pkg.sv */
/*
 * Shared constants and types of the execute datapath: operation codes,
 * sequencing states, memory widths, register map and flag positions.
 * Assumes an 8-bit core with synchronous data and program memories.
 */
package miex_pkg;

	// Memory and datapath widths
	localparam int DW      = 8;
	localparam int DM_AW   = 12;        // Far address reaches every data memory section
	localparam int PM_AW   = 16;
	localparam int PM_DW   = 16;
	localparam int AXI_AW  = 8;
	localparam int AXI_DW  = 32;
	localparam logic [7:0] FINAL_PAGE = 8'hFF;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_WORK    = 8'h08;
	localparam logic [7:0] REG_TBLPTR  = 8'h0C;
	localparam logic [7:0] REG_TBLHIGH = 8'h10;
	localparam logic [7:0] REG_FLAGS   = 8'h14;

	// Field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int FLG_C           = 0;     // Carry
	localparam int FLG_NC          = 1;     // Nibble carry
	localparam int FLG_Z           = 2;     // Zero
	localparam int FLG_SR          = 3;     // Signed range (overflow)
	localparam int FLG_SS          = 4;     // Signed result
	localparam int FLG_W           = 5;

	// Reset values
	localparam logic             CTRL_EN_RST = 1'b1;
	localparam logic [7:0]       WORK_RST    = 8'h00;
	localparam logic [7:0]       PTR_RST     = 8'h00;
	localparam logic [FLG_W-1:0] FLAGS_RST   = 5'h00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Decimal adjust figures
	localparam logic [3:0] BCD_LIMIT = 4'h9;
	localparam logic [3:0] BCD_FIX   = 4'h6;

	typedef enum logic [4:0] {
		OP_NIB_SWAP     = 5'h00, OP_NIB_SWAP_W  = 5'h01, OP_SKIP_ZERO = 5'h02,
		OP_COPY_SKIP    = 5'h03, OP_SKIP_BIT    = 5'h04, OP_TBL_PAGED = 5'h05,
		OP_TBL_FINAL    = 5'h06, OP_TBL_PAGED_I = 5'h07, OP_TBL_FINAL_I = 5'h08,
		OP_XOR_W        = 5'h09, OP_XOR_M       = 5'h0A, OP_XOR_IMM   = 5'h0B,
		OP_ADD_C_W      = 5'h0C, OP_ADD_C_M     = 5'h0D, OP_ADD_W     = 5'h0E,
		OP_ADD_M        = 5'h0F, OP_AND_W       = 5'h10, OP_AND_M     = 5'h11,
		OP_CLR          = 5'h12, OP_CLR_BIT     = 5'h13, OP_INV_M     = 5'h14,
		OP_INV_W        = 5'h15, OP_DEC_ADJ     = 5'h16, OP_DEC_M     = 5'h17,
		OP_DEC_W        = 5'h18, OP_INC_M       = 5'h19, OP_INC_W     = 5'h1A,
		OP_MOV_TO_W     = 5'h1B, OP_MOV_TO_M    = 5'h1C
	} miex_op_e;

	// Gray sequence along IDLE -> MRD -> EXEC -> DUMMY
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_MRD   = 3'h1,
		ST_EXEC  = 3'h3,
		ST_DUMMY = 3'h2,
		ST_PMRD  = 3'h7
	} miex_state_e;

endpackage : miex_pkg

/* hdl/miex_execute_datapath.sv */
/*
 * Execute datapath for nibble swap, zero skips, table fetches, exclusive-OR
 * and the far-addressed arithmetic, logic and move operations.
 * Assumes data and program memories answer one cycle after a read strobe,
 * a sequencer that offers one operation at a time, and an AXI4-Lite master.
 */
// Added by the designer: the AXI4-Lite register port and the address map.
// Contract
// - Nibble swap exchanges byte halves, writes back to memory, flags unchanged
// - Swap-to-work puts swapped byte in work register, memory and flags untouched
// - Skip when zero skips next instruction if whole byte is zero, no flags
// - Copy-then-skip loads byte into work register, skips if zero, no flags
// - Bit skip tests only selected bit, skips when it is zero, no flags
// - A taken skip inserts a dummy cycle, making the instruction two cycles
// - Paged table fetch reads word at both pointers, low to memory, high latched
// - Final-page fetch uses last page and low pointer only
// - Preincrementing paged fetch bumps low pointer before reading the word
// - Preincrementing final-page fetch bumps low pointer before reading last page
// - Exclusive-OR with memory or immediate, to work or memory, zero flag only
// - Far forms address any data memory section directly
// - Far add with carry sums work, byte and carry, updates five flags
// - Far add sums work and byte, updates the same five flags
// - Far AND combines work and byte bitwise, zero flag only
// - Far clear writes zero to byte, bit form clears one bit, no flags
// - Far invert complements byte to memory or work, zero flag updated
// - Far decimal adjust adds 00/06/60/66 to work, result to memory, carry only
// - Far decrement subtracts one to memory or work, zero flag updated
// - Far increment adds one to memory or work, zero flag updated
// - Far move copies byte to work or work to byte, no flags
`timescale 1ns/1ps
module miex_execute_datapath (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      opValid,
	output logic                           opReady,
	input  wire miex_pkg::miex_op_e        opCode,
	input  wire logic [miex_pkg::DM_AW-1:0] opAddr,
	input  wire logic [2:0]                opBit,
	input  wire logic [miex_pkg::DW-1:0]    opImm,
	output logic                           opDone,
	output logic                           skipNext,
	output logic                           dummyCycle,
	output logic [miex_pkg::DM_AW-1:0]      dmAddr,
	output logic                           dmRdEn,
	input  wire logic [miex_pkg::DW-1:0]    dmRdData,
	output logic                           dmWrEn,
	output logic [miex_pkg::DW-1:0]         dmWrData,
	output logic [miex_pkg::PM_AW-1:0]      pmAddr,
	output logic                           pmRdEn,
	input  wire logic [miex_pkg::PM_DW-1:0] pmRdData,
	output logic [miex_pkg::DW-1:0]         workReg,
	output logic [miex_pkg::DW-1:0]         tableHigh,
	output logic                           carryFlag,
	output logic                           nibbleCarryFlag,
	output logic                           zeroFlag,
	output logic                           signedRangeFlag,
	output logic                           signedResultFlag,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [miex_pkg::AXI_AW-1:0] awaddr,
	input  wire logic [2:0]                awprot,
	input  wire logic                      wvalid,
	output logic                           wready,
	input  wire logic [miex_pkg::AXI_DW-1:0] wdata,
	input  wire logic [3:0]                wstrb,
	output logic                           bvalid,
	input  wire logic                      bready,
	output logic [1:0]                     bresp,
	input  wire logic                      arvalid,
	output logic                           arready,
	input  wire logic [miex_pkg::AXI_AW-1:0] araddr,
	input  wire logic [2:0]                arprot,
	output logic                           rvalid,
	input  wire logic                      rready,
	output logic [miex_pkg::AXI_DW-1:0]     rdata,
	output logic [1:0]                     rresp
);
	import miex_pkg::*;

	miex_state_e            state_ff;
	miex_op_e               op_ff;
	logic [2:0]             bit_ff;
	logic [DW-1:0]          imm_ff;
	logic                   opReady_ff, opDone_ff, skip_ff, dummy_ff;
	logic [DM_AW-1:0]       dmAddr_ff;
	logic                   dmRdEn_ff, dmWrEn_ff, pmRdEn_ff;
	logic [DW-1:0]          dmWrData_ff;
	logic [PM_AW-1:0]       pmAddr_ff;
	logic [DW-1:0]          work_ff, ptrLow_ff, ptrHigh_ff, tblHigh_ff;
	logic [FLG_W-1:0]       flags_ff;
	logic                   ctrlEn_ff;
	logic                   awReady_ff, awHeld_ff, wReady_ff, wHeld_ff, bValid_ff;
	logic [AXI_AW-1:0]      awAddr_ff;
	logic [AXI_DW-1:0]      wData_ff;
	logic [3:0]             wStrb_ff;
	logic [1:0]             bResp_ff, rResp_ff;
	logic                   arReady_ff, rValid_ff;
	logic [AXI_DW-1:0]      rData_ff;

	logic                   accept, isTable, isPreinc, isFinal, doWrite, wrHit;
	logic [DW-1:0]          nxt_ptrLow;
	logic [DW-1:0]          res;
	logic                   wrMem, wrAcc, updZ, updArith, updDaa, doSkip;
	logic                   addCin, ovf, lowFix, highFix;
	logic [DW:0]            sum9, daaSum;
	logic [4:0]             nibSum;
	logic [DW-1:0]          wordLow;

	// Operation class decode for the fetch path
	assign accept   = opValid && opReady_ff;
	assign isTable  = opCode inside {OP_TBL_PAGED, OP_TBL_FINAL, OP_TBL_PAGED_I, OP_TBL_FINAL_I};
	assign isPreinc = opCode inside {OP_TBL_PAGED_I, OP_TBL_FINAL_I};
	assign isFinal  = opCode inside {OP_TBL_FINAL, OP_TBL_FINAL_I};
	assign nxt_ptrLow = isPreinc ? ptrLow_ff + 8'h01 : ptrLow_ff;

	// Adder and its flag terms share one carry-in select; decimal adjust uses the carry flags
	assign addCin = (op_ff == OP_ADD_C_W || op_ff == OP_ADD_C_M) && flags_ff[FLG_C];
	assign sum9   = {1'b0, work_ff} + {1'b0, dmRdData} + {8'h00, addCin};
	assign nibSum = {1'b0, work_ff[3:0]} + {1'b0, dmRdData[3:0]} + {4'h0, addCin};
	assign ovf    = (work_ff[7] == dmRdData[7]) && (sum9[7] != work_ff[7]);
	assign lowFix  = (work_ff[3:0] > BCD_LIMIT) || flags_ff[FLG_NC];
	assign highFix = (work_ff[7:4] > BCD_LIMIT) || flags_ff[FLG_C];
	assign daaSum = {1'b0, work_ff} + {1'b0, (highFix ? BCD_FIX : 4'h0), (lowFix ? BCD_FIX : 4'h0)};
	assign wordLow = pmRdData[DW-1:0];

	// Result select; memory data is valid during the execute state
	always_comb begin
		res = dmRdData;
		wrMem = 1'b0;
		wrAcc = 1'b0;
		updZ = 1'b0;
		updArith = 1'b0;
		updDaa = 1'b0;
		doSkip = 1'b0;
		case (op_ff)
			OP_NIB_SWAP: begin
				res = {dmRdData[3:0], dmRdData[7:4]};
				wrMem = 1'b1;
			end
			OP_NIB_SWAP_W: begin
				res = {dmRdData[3:0], dmRdData[7:4]};
				wrAcc = 1'b1;
			end
			OP_SKIP_ZERO: doSkip = (dmRdData == 8'h00);
			OP_COPY_SKIP: begin
				wrAcc = 1'b1;
				doSkip = (dmRdData == 8'h00);
			end
			OP_SKIP_BIT: doSkip = !dmRdData[bit_ff];
			OP_TBL_PAGED, OP_TBL_FINAL, OP_TBL_PAGED_I, OP_TBL_FINAL_I: begin
				res = wordLow;
				wrMem = 1'b1;
			end
			OP_XOR_W, OP_XOR_M: begin
				res = work_ff ^ dmRdData;
				wrMem = (op_ff == OP_XOR_M);
				wrAcc = (op_ff == OP_XOR_W);
				updZ = 1'b1;
			end
			OP_XOR_IMM: begin
				res = work_ff ^ imm_ff;
				wrAcc = 1'b1;
				updZ = 1'b1;
			end
			OP_ADD_C_W, OP_ADD_C_M, OP_ADD_W, OP_ADD_M: begin
				res = sum9[DW-1:0];
				wrMem = (op_ff == OP_ADD_C_M) || (op_ff == OP_ADD_M);
				wrAcc = !wrMem;
				updArith = 1'b1;
			end
			OP_AND_W, OP_AND_M: begin
				res = work_ff & dmRdData;
				wrMem = (op_ff == OP_AND_M);
				wrAcc = !wrMem;
				updZ = 1'b1;
			end
			OP_CLR: begin
				res = 8'h00;
				wrMem = 1'b1;
			end
			OP_CLR_BIT: begin
				res = dmRdData & ~(8'h01 << bit_ff);
				wrMem = 1'b1;
			end
			OP_INV_M, OP_INV_W: begin
				res = ~dmRdData;
				wrMem = (op_ff == OP_INV_M);
				wrAcc = !wrMem;
				updZ = 1'b1;
			end
			OP_DEC_ADJ: begin
				res = daaSum[DW-1:0];
				wrMem = 1'b1;
				updDaa = 1'b1;
			end
			OP_DEC_M, OP_DEC_W: begin
				res = dmRdData - 8'h01;
				wrMem = (op_ff == OP_DEC_M);
				wrAcc = !wrMem;
				updZ = 1'b1;
			end
			OP_INC_M, OP_INC_W: begin
				res = dmRdData + 8'h01;
				wrMem = (op_ff == OP_INC_M);
				wrAcc = !wrMem;
				updZ = 1'b1;
			end
			OP_MOV_TO_W: wrAcc = 1'b1;
			OP_MOV_TO_M: begin
				res = work_ff;
				wrMem = 1'b1;
			end
			default: res = dmRdData;
		endcase
	end

	// Sequencer: take one operation, read, execute, optional dummy cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			op_ff <= OP_NIB_SWAP;
			bit_ff <= 3'h0;
			imm_ff <= 8'h00;
			opReady_ff <= 1'b0;
			opDone_ff <= 1'b0;
			skip_ff <= 1'b0;
			dummy_ff <= 1'b0;
			dmAddr_ff <= '0;
			dmRdEn_ff <= 1'b0;
			pmRdEn_ff <= 1'b0;
			pmAddr_ff <= '0;
		end else begin
			opDone_ff <= 1'b0;
			skip_ff <= 1'b0;
			dummy_ff <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					opReady_ff <= ctrlEn_ff;
					if (accept) begin
						opReady_ff <= 1'b0;
						op_ff <= opCode;
						bit_ff <= opBit;
						imm_ff <= opImm;
						dmAddr_ff <= opAddr;
						if (isTable) begin
							pmRdEn_ff <= 1'b1;
							pmAddr_ff <= {(isFinal ? FINAL_PAGE : ptrHigh_ff), nxt_ptrLow};
							state_ff <= ST_PMRD;
						end else begin
							dmRdEn_ff <= 1'b1;
							state_ff <= ST_MRD;
						end
					end
				end
				ST_MRD: begin
					dmRdEn_ff <= 1'b0;
					state_ff <= ST_EXEC;
				end
				ST_PMRD: begin
					pmRdEn_ff <= 1'b0;
					state_ff <= ST_EXEC;
				end
				ST_EXEC: begin
					if (doSkip) begin
						dummy_ff <= 1'b1;
						state_ff <= ST_DUMMY;
					end else begin
						opDone_ff <= 1'b1;
						opReady_ff <= ctrlEn_ff;
						state_ff <= ST_IDLE;
					end
				end
				ST_DUMMY: begin
					opDone_ff <= 1'b1;
					skip_ff <= 1'b1;
					opReady_ff <= ctrlEn_ff;
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Data memory write strobe, one cycle after execute
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dmWrEn_ff <= 1'b0;
			dmWrData_ff <= 8'h00;
		end else begin
			dmWrEn_ff <= (state_ff == ST_EXEC) && wrMem;
			if (state_ff == ST_EXEC && wrMem)
				dmWrData_ff <= res;
		end
	end

	// Work register, table pointers and latch; datapath wins over software
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			work_ff <= WORK_RST;
			ptrLow_ff <= PTR_RST;
			ptrHigh_ff <= PTR_RST;
			tblHigh_ff <= 8'h00;
		end else begin
			if (state_ff == ST_EXEC && wrAcc)
				work_ff <= res;
			else if (wrHit && awAddr_ff == REG_WORK && wStrb_ff[0])
				work_ff <= wData_ff[7:0];
			if (state_ff == ST_IDLE && accept && isTable)
				ptrLow_ff <= nxt_ptrLow;
			else if (wrHit && awAddr_ff == REG_TBLPTR && wStrb_ff[0])
				ptrLow_ff <= wData_ff[7:0];
			if (wrHit && awAddr_ff == REG_TBLPTR && wStrb_ff[1])
				ptrHigh_ff <= wData_ff[15:8];
			if (state_ff == ST_EXEC && isTableOp(op_ff))
				tblHigh_ff <= pmRdData[PM_DW-1:DW];
		end
	end

	function automatic logic isTableOp(input miex_op_e o);
		isTableOp = (o == OP_TBL_PAGED) || (o == OP_TBL_FINAL) ||
			(o == OP_TBL_PAGED_I) || (o == OP_TBL_FINAL_I);
	endfunction : isTableOp

	// Flags; the zero test covers the full eight-bit result
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_ff <= FLAGS_RST;
		end else if (state_ff == ST_EXEC && (updZ || updArith || updDaa)) begin
			if (updZ || updArith)
				flags_ff[FLG_Z] <= (res == 8'h00);
			if (updArith) begin
				flags_ff[FLG_C] <= sum9[DW];
				flags_ff[FLG_NC] <= nibSum[4];
				flags_ff[FLG_SR] <= ovf;
				flags_ff[FLG_SS] <= ovf ^ sum9[7];
			end
			if (updDaa)
				flags_ff[FLG_C] <= flags_ff[FLG_C] | daaSum[DW];
		end else if (wrHit && awAddr_ff == REG_FLAGS && wStrb_ff[0]) begin
			flags_ff <= wData_ff[FLG_W-1:0];
		end
	end

	// Control register; clearing enable stops new operations being taken
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ctrlEn_ff <= CTRL_EN_RST;
		else if (wrHit && awAddr_ff == REG_CTRL && wStrb_ff[0])
			ctrlEn_ff <= wData_ff[CTRL_EN_BIT];
	end

	// Write address and data are taken in either order, response after both
	assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
	assign wrHit = doWrite && (awAddr_ff == REG_CTRL || awAddr_ff == REG_WORK ||
		awAddr_ff == REG_TBLPTR || awAddr_ff == REG_FLAGS);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awReady_ff <= 1'b0;
			awHeld_ff <= 1'b0;
			awAddr_ff <= '0;
			wReady_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			wData_ff <= '0;
			wStrb_ff <= 4'h0;
			bValid_ff <= 1'b0;
			bResp_ff <= RESP_OKAY;
		end else begin
			if (awvalid && awReady_ff) begin
				awAddr_ff <= {awaddr[AXI_AW-1:2], 2'h0};
				awHeld_ff <= 1'b1;
				awReady_ff <= 1'b0;
			end else if (!awHeld_ff && !bValid_ff) begin
				awReady_ff <= 1'b1;
			end
			if (wvalid && wReady_ff) begin
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
				wHeld_ff <= 1'b1;
				wReady_ff <= 1'b0;
			end else if (!wHeld_ff && !bValid_ff) begin
				wReady_ff <= 1'b1;
			end
			if (doWrite) begin
				bValid_ff <= 1'b1;
				bResp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR; // Read-only or unmapped
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
			end else if (bValid_ff && bready) begin
				bValid_ff <= 1'b0;
			end
		end
	end

	// Read channel; unmapped reads return zero with an error response
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arReady_ff <= 1'b0;
			rValid_ff <= 1'b0;
			rData_ff <= '0;
			rResp_ff <= RESP_OKAY;
		end else if (arvalid && arReady_ff) begin
			arReady_ff <= 1'b0;
			rValid_ff <= 1'b1;
			rResp_ff <= RESP_OKAY;
			case ({araddr[AXI_AW-1:2], 2'h0})
				REG_CTRL:    rData_ff <= {31'h0, ctrlEn_ff};
				REG_STATUS:  rData_ff <= {31'h0, state_ff != ST_IDLE};
				REG_WORK:    rData_ff <= {24'h0, work_ff};
				REG_TBLPTR:  rData_ff <= {16'h0, ptrHigh_ff, ptrLow_ff};
				REG_TBLHIGH: rData_ff <= {24'h0, tblHigh_ff};
				REG_FLAGS:   rData_ff <= {27'h0, flags_ff};
				default: begin
					rData_ff <= '0;
					rResp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (rValid_ff && rready) begin
			rValid_ff <= 1'b0;
		end else if (!rValid_ff) begin
			arReady_ff <= 1'b1;
		end
	end

	// Outputs straight from flops
	assign opReady = opReady_ff;
	assign opDone = opDone_ff;
	assign skipNext = skip_ff;
	assign dummyCycle = dummy_ff;
	assign dmAddr = dmAddr_ff;
	assign dmRdEn = dmRdEn_ff;
	assign dmWrEn = dmWrEn_ff;
	assign dmWrData = dmWrData_ff;
	assign pmAddr = pmAddr_ff;
	assign pmRdEn = pmRdEn_ff;
	assign workReg = work_ff;
	assign tableHigh = tblHigh_ff;
	assign carryFlag = flags_ff[FLG_C];
	assign nibbleCarryFlag = flags_ff[FLG_NC];
	assign zeroFlag = flags_ff[FLG_Z];
	assign signedRangeFlag = flags_ff[FLG_SR];
	assign signedResultFlag = flags_ff[FLG_SS];
	assign awready = awReady_ff;
	assign wready = wReady_ff;
	assign bvalid = bValid_ff;
	assign bresp = bResp_ff;
	assign arready = arReady_ff;
	assign rvalid = rValid_ff;
	assign rdata = rData_ff;
	assign rresp = rResp_ff;

	// Checks on the datapath
	nib_swap_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == ST_EXEC && op_ff == OP_NIB_SWAP) |=> dmWrEn &&
		dmWrData == {$past(dmRdData[3:0]), $past(dmRdData[7:4])} && $stable(flags_ff))
		else $error("nibble swap write wrong");
	swap_work_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == ST_EXEC && op_ff == OP_NIB_SWAP_W) |=> !dmWrEn &&
		workReg == {$past(dmRdData[3:0]), $past(dmRdData[7:4])})
		else $error("swap to work wrong");
	zero_skip_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == ST_EXEC && op_ff == OP_SKIP_ZERO && dmRdData == 8'h00) |=>
		dummyCycle && !opDone ##1 opDone && skipNext)
		else $error("zero skip missing");
	copy_skip_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == ST_EXEC && op_ff == OP_COPY_SKIP) |=> workReg == $past(dmRdData))
		else $error("copy skip load wrong");
	bit_skip_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == ST_EXEC && op_ff == OP_SKIP_BIT && dmRdData[bit_ff]) |=>
		opDone && !skipNext && !dummyCycle)
		else $error("bit skip taken wrongly");
	final_page_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == ST_PMRD && (op_ff == OP_TBL_FINAL || op_ff == OP_TBL_FINAL_I)) |->
		pmRdEn && pmAddr[PM_AW-1:DW] == FINAL_PAGE && pmAddr[DW-1:0] == ptrLow_ff)
		else $error("final page address wrong");
	pre_inc_a: assert property (@(posedge clk) disable iff (!rstn)
		(accept && state_ff == ST_IDLE && opCode == OP_TBL_PAGED_I) |=>
		ptrLow_ff == $past(ptrLow_ff) + 8'h01 ##2 dmWrEn)
		else $error("pointer not incremented first");
	xor_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == ST_EXEC && op_ff == OP_XOR_W) |=>
		workReg == ($past(work_ff) ^ $past(dmRdData)) && zeroFlag == (workReg == 8'h00))
		else $error("xor result or zero flag wrong");
endmodule : miex_execute_datapath

/* verif/miex_mem_model.sv */
/* Data and program memory model beside the execute datapath.
   Assumes one-cycle read latency; idle outputs flip so stale sampling shows. */
`timescale 1ns/1ps
module miex_mem_model (
	input  wire logic        clk,
	input  wire logic [11:0] dmAddr,
	input  wire logic        dmRdEn,
	output logic      [7:0]  dmRdData,
	input  wire logic        dmWrEn,
	input  wire logic [7:0]  dmWrData,
	input  wire logic [15:0] pmAddr,
	input  wire logic        pmRdEn,
	output logic      [15:0] pmRdData
);
	logic [7:0] mem [4096];
	// Answers one cycle after a strobe; program word is {page, low ^ A5}
	always @(posedge clk) begin
		dmRdData <= dmRdEn ? mem[dmAddr] : ~dmRdData;
		pmRdData <= pmRdEn ? {pmAddr[15:8], pmAddr[7:0] ^ 8'hA5} : ~pmRdData;
		if (dmWrEn) begin
			mem[dmAddr] <= dmWrData;
		end
	end
endmodule : miex_mem_model

/* verif/tb_miex_execute_datapath.sv */
/* Bench of the execute datapath: register bus, operation rows and table fetches.
   Assumes the memory model and its program word pattern. */
`timescale 1ns/1ps
module tb_miex_execute_datapath;
	import miex_pkg::*;
	localparam logic [11:0] FA = 12'hF37;                 // Far address, top section
	localparam logic [63:0] TB = 64'h5B125BFF5A12A5FF;    // Low byte, latch per fetch
	logic        clk = 1'b0, rstn, opValid, awvalid, wvalid, bready, arvalid, rready;
	logic        opReady, opDone, skipNext, dummyCycle, dmRdEn, dmWrEn, pmRdEn, awready;
	logic        carryFlag, nibbleCarryFlag, zeroFlag, signedRangeFlag, signedResultFlag;
	logic        wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [2:0]  opBit, awprot, arprot;
	logic [3:0]  wstrb;
	logic [7:0]  opImm, awaddr, araddr, dmRdData, dmWrData, workReg, tableHigh;
	logic [11:0] opAddr, dmAddr;
	logic [15:0] pmAddr, pmRdData;
	logic [31:0] wdata, rdata;
	miex_op_e    opCode;
	int          errTotal = 0, comparisons = 0, cyc = 0;
	wire logic [4:0] flg = {signedResultFlag, signedRangeFlag, zeroFlag, nibbleCarryFlag, carryFlag};

	miex_execute_datapath DUT (.clk, .rstn, .opValid, .opReady, .opCode, .opAddr, .opBit, .opImm,
		.opDone, .skipNext, .dummyCycle, .dmAddr, .dmRdEn, .dmRdData, .dmWrEn, .dmWrData, .pmAddr,
		.pmRdEn, .pmRdData, .workReg, .tableHigh, .carryFlag, .nibbleCarryFlag, .zeroFlag,
		.signedRangeFlag, .signedResultFlag, .awvalid, .awready, .awaddr, .awprot, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
		.rvalid, .rready, .rdata, .rresp);
	miex_mem_model u_mem (.clk, .dmAddr, .dmRdEn, .dmRdData, .dmWrEn, .dmWrData, .pmAddr,
		.pmRdEn, .pmRdData);

	// Counted compare
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			errTotal++;
			$display("[ERR] %0d ns: got %h, expected %h", $time, g, x);
		end
	endtask : chk

	task automatic completeRun;
		$display("Compares %0d, mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : completeRun

	// 200 MHz clock
	initial forever #2.5 clk = ~clk;

	// Watchdog: every wait below relies on this bound
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errTotal++;
			$display("[ERR] %0d ns: watchdog expired", $time);
			completeRun();
		end
	end

	// Write: address and data offered together, each dropped once taken
	// Response ready stays high between calls so back-to-back writes never toggle it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(32'(bresp), 32'(r));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		chk(rdata, e);
		chk(32'(rresp), 32'(r));
	endtask : rd

	// One operation; skip and dummy pulses are caught at the edges they stand
	task automatic op(input miex_op_e c, input logic [7:0] x, input logic s);
		logic d, k;
		d = 1'b0;
		opValid <= 1'b1;
		opCode <= c;
		opAddr <= FA;
		opBit <= x[2:0];
		opImm <= x;
		do @(posedge clk); while (opReady !== 1'b1);
		opValid <= 1'b0;
		do begin
			@(posedge clk);
			d |= (dummyCycle === 1'b1);
			k = skipNext;
		end while (opDone !== 1'b1);
		// One more edge lets the memory write land before the row is checked
		@(posedge clk);
		chk(32'(k), 32'(s));
		chk(32'(d), 32'(s));
	endtask : op

	// Row bytes: work, memory, imm/bit, flags in, result, flags out, {to memory, skip}
	task automatic alu(input miex_op_e c, input logic [55:0] v);
		wr(REG_WORK, 32'(v[55:48]), RESP_OKAY);
		wr(REG_FLAGS, 32'(v[31:24]), RESP_OKAY);
		u_mem.mem[FA] = v[47:40];
		op(c, v[39:32], v[0]);
		chk(32'(u_mem.mem[FA]), 32'(v[4] ? v[23:16] : v[47:40]));
		chk(32'(workReg), 32'(v[4] ? v[55:48] : v[23:16]));
		chk(32'(flg), 32'(v[15:8]));
	endtask : alu

	initial begin
		{rstn, opValid, awvalid, wvalid, bready, arvalid, rready, opBit, awprot, arprot} = '0;
		{opImm, awaddr, araddr, opAddr, wdata} = '0;
		wstrb = 4'hF;
		opCode = OP_NIB_SWAP;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rd(REG_CTRL, 32'h1, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(REG_STATUS, 32'h1, RESP_SLVERR);
		// Disabled core refuses operations, then is enabled again
		wr(REG_CTRL, 32'h0, RESP_OKAY);
		rd(REG_CTRL, 32'h0, RESP_OKAY);
		chk(32'(opReady), 32'h0);
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		rd(REG_STATUS, 32'h0, RESP_OKAY);
		alu(OP_NIB_SWAP, 56'h004B0015B41510);
		alu(OP_NIB_SWAP_W, 56'h004B0015B41500);
		alu(OP_SKIP_ZERO, 56'h00000015001511);
		alu(OP_SKIP_ZERO, 56'h00800015801510);
		alu(OP_COPY_SKIP, 56'h11000015001501);
		alu(OP_SKIP_BIT, 56'h00F70315F71511);
		alu(OP_SKIP_BIT, 56'h00F70415F71510);
		alu(OP_XOR_W, 56'h5A5A0000000400);
		alu(OP_XOR_M, 56'h0FF00004FF0010);
		alu(OP_XOR_IMM, 56'h0F0FF004FF0000);
		alu(OP_ADD_C_W, 56'h7F000001800A00);
		alu(OP_ADD_C_M, 56'hFF000001000710);
		alu(OP_ADD_W, 56'h80800001001D00);
		alu(OP_ADD_M, 56'h08080000100210);
		alu(OP_AND_W, 56'hF00F001B001F00);
		alu(OP_AND_M, 56'hF03C001F301B10);
		alu(OP_CLR, 56'h00A5001F001F10);
		alu(OP_CLR_BIT, 56'h00FF0500DF0010);
		alu(OP_INV_M, 56'h00FF0000000410);
		alu(OP_INV_W, 56'h000F0004F00000);
		alu(OP_DEC_ADJ, 56'h350000039B0310);
		alu(OP_DEC_ADJ, 56'hAB000000110110);
		alu(OP_DEC_M, 56'h00010000000410);
		alu(OP_DEC_W, 56'h00000004FF0000);
		alu(OP_INC_M, 56'h00FF0000000410);
		alu(OP_INC_W, 56'h007F0004800000);
		alu(OP_MOV_TO_W, 56'h00C3001FC31F00);
		alu(OP_MOV_TO_M, 56'h3C00001F3C1F10);
		wr(REG_TBLPTR, 32'h000034FE, RESP_OKAY);
		wstrb <= 4'h2;
		wr(REG_TBLPTR, 32'h000012AA, RESP_OKAY); // Only the high pointer lane is enabled
		wstrb <= 4'hF;
		for (int i = 0; i < 4; i++) begin
			op(miex_op_e'(OP_TBL_PAGED + i), 8'h00, 1'b0);
			chk(32'(u_mem.mem[FA]), 32'(TB[63-16*i -: 8]));
			chk(32'(tableHigh), 32'(TB[55-16*i -: 8]));
		end
		rd(REG_TBLPTR, 32'h00001200, RESP_OKAY);
		rd(REG_TBLHIGH, 32'h000000FF, RESP_OKAY);
		rd(REG_FLAGS, 32'h0000001F, RESP_OKAY);
		completeRun();
	end
endmodule : tb_miex_execute_datapath
